/* src/psp_top.sv */
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "psp_map.svh"
module psp_top (
	input  wire logic        clock,
	input  wire logic        rst_b,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [7:0]  port_d_in,
	output logic      [7:0]  port_d_out,
	output logic      [7:0]  port_d_oe,
	input  wire logic [2:0]  port_e_in,
	output logic      [2:0]  port_e_out,
	output logic      [2:0]  port_e_oe,
	output logic             port_int_req
);
	logic [7:0]          pd_s1_q;
	logic [7:0]          pd_s2_q;
	logic [2:0]          pe_s1_q;
	logic [2:0]          pe_s2_q;

	logic [7:0]          out_latch_q;
	logic [7:0]          in_latch_q;
	logic [7:0]          dir_d_q;
	logic [7:0]          port_e_q;
	logic [7:0]          int_ctrl_q;
	logic [7:0]          int_flags_low_q;
	logic [7:0]          int_en_q;
	logic [7:0]          prdata_q;
	logic [2:0]          dir_e_q;
	logic [2:0]          cfg_q;
	logic                mode_q;
	logic                in_full_q;
	logic                out_full_q;
	logic                in_ovf_q;
	logic                pif_q;

	logic                wr_act_q;
	logic                rd_act_q;
	logic                slave_en;
	logic                rd_act;
	logic                wr_act;
	logic                wr_start;
	logic                wr_end;
	logic                rd_start;
	logic                rd_end;

	logic                setup;
	logic                acc_wr;
	logic                acc_rd;
	logic                hit;
	logic                wr_q4;
	logic                rd_q4;
	logic [9:0]          idx;
	logic [7:0]          rd_val;
	psp_pkg::psp_phase_t phase_q;
	psp_pkg::psp_evt_t   wev_q;
	psp_pkg::psp_evt_t   rev_q;

	// Pin synchronisers
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pd_s1_q <= 8'h00;
			pd_s2_q <= 8'h00;
			pe_s1_q <= 3'h7;
			pe_s2_q <= 3'h7;
		end else begin
			pd_s1_q <= port_d_in;
			pd_s2_q <= pd_s1_q;
			pe_s1_q <= port_e_in;
			pe_s2_q <= pe_s1_q;
		end
	end

	// Slave mode qualification and strobe decode
	assign slave_en = mode_q && (dir_e_q == `PSP_DIR_ALL_IN) && (cfg_q == `PSP_CFG_DIGITAL);
	assign rd_act   = slave_en && !pe_s2_q[2] && !pe_s2_q[0];
	assign wr_act   = slave_en && !pe_s2_q[2] && !pe_s2_q[1];
	assign wr_start = wr_act && !wr_act_q;
	assign wr_end   = !wr_act && wr_act_q;
	assign rd_start = rd_act && !rd_act_q;
	assign rd_end   = !rd_act && rd_act_q;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			wr_act_q <= 1'b0;
			rd_act_q <= 1'b0;
		end else begin
			wr_act_q <= wr_act;
			rd_act_q <= rd_act;
		end
	end

	// Instruction phase counter
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			phase_q <= psp_pkg::PSP_Q1;
		end else begin
			case (phase_q)
				psp_pkg::PSP_Q1: phase_q <= psp_pkg::PSP_Q2;
				psp_pkg::PSP_Q2: phase_q <= psp_pkg::PSP_Q3;
				psp_pkg::PSP_Q3: phase_q <= psp_pkg::PSP_Q4;
				default:         phase_q <= psp_pkg::PSP_Q1;
			endcase
		end
	end

	// Write completion: Q4 after the next Q2
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			wev_q <= psp_pkg::PSP_EV_IDLE;
		end else begin
			case (wev_q)
				psp_pkg::PSP_EV_IDLE: begin
					if (wr_end) begin
						wev_q <= psp_pkg::PSP_EV_WAIT_Q2;
					end
				end
				psp_pkg::PSP_EV_WAIT_Q2: begin
					if (phase_q == psp_pkg::PSP_Q2) begin
						wev_q <= psp_pkg::PSP_EV_WAIT_Q4;
					end
				end
				psp_pkg::PSP_EV_WAIT_Q4: begin
					if (phase_q == psp_pkg::PSP_Q4) begin
						wev_q <= wr_end ? psp_pkg::PSP_EV_WAIT_Q2 : psp_pkg::PSP_EV_IDLE;
					end
				end
				default: wev_q <= psp_pkg::PSP_EV_IDLE;
			endcase
		end
	end

	// Read completion: Q4 after the next Q2
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rev_q <= psp_pkg::PSP_EV_IDLE;
		end else begin
			case (rev_q)
				psp_pkg::PSP_EV_IDLE: begin
					if (rd_end) begin
						rev_q <= psp_pkg::PSP_EV_WAIT_Q2;
					end
				end
				psp_pkg::PSP_EV_WAIT_Q2: begin
					if (phase_q == psp_pkg::PSP_Q2) begin
						rev_q <= psp_pkg::PSP_EV_WAIT_Q4;
					end
				end
				psp_pkg::PSP_EV_WAIT_Q4: begin
					if (phase_q == psp_pkg::PSP_Q4) begin
						rev_q <= rd_end ? psp_pkg::PSP_EV_WAIT_Q2 : psp_pkg::PSP_EV_IDLE;
					end
				end
				default: rev_q <= psp_pkg::PSP_EV_IDLE;
			endcase
		end
	end

	assign wr_q4 = (wev_q == psp_pkg::PSP_EV_WAIT_Q4) && (phase_q == psp_pkg::PSP_Q4);
	assign rd_q4 = (rev_q == psp_pkg::PSP_EV_WAIT_Q4) && (phase_q == psp_pkg::PSP_Q4);

	// APB decode
	assign idx     = paddr[11:2];
	assign setup   = psel && !penable;
	assign acc_wr  = psel && penable && pwrite && hit;
	assign acc_rd  = psel && penable && !pwrite && hit;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !hit;
	assign prdata  = {24'h000000, prdata_q};

	// Register read mux
	always_comb begin
		hit    = (paddr[1:0] == 2'h0);
		rd_val = 8'h00;
		case (idx)
			`PSP_IDX_PORT_D: begin
				rd_val = slave_en ? in_latch_q : pd_s2_q;
			end
			`PSP_IDX_PORT_E: begin
				rd_val = {5'h00, pe_s2_q};
			end
			`PSP_IDX_INT_CTRL: begin
				rd_val = int_ctrl_q;
			end
			`PSP_IDX_INT_FLAGS: begin
				rd_val = {pif_q, int_flags_low_q[6:0]};
			end
			`PSP_IDX_PORT_D_DIR: begin
				rd_val = dir_d_q;
			end
			`PSP_IDX_DIR_STAT: begin
				rd_val = {in_full_q, out_full_q, in_ovf_q, mode_q, 1'b0, dir_e_q};
			end
			`PSP_IDX_INT_EN: begin
				rd_val = int_en_q;
			end
			`PSP_IDX_PIN_CFG: begin
				rd_val = {5'h00, cfg_q};
			end
			default: begin
				hit = 1'b0;
			end
		endcase
	end

	// Refused accesses read as zero
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			prdata_q <= 8'h00;
		end else if (setup) begin
			prdata_q <= hit ? rd_val : 8'h00;
		end
	end

	// Slave mode select
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			mode_q <= 1'b0;
		end else if (acc_wr && (idx == `PSP_IDX_DIR_STAT)) begin
			mode_q <= pwdata[`PSP_BIT_MODE];
		end
	end

	// Port E direction
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			dir_e_q <= `PSP_RST_DIR_E;
		end else if (acc_wr && (idx == `PSP_IDX_DIR_STAT)) begin
			dir_e_q <= pwdata[2:0];
		end
	end

	// Port D direction
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			dir_d_q <= `PSP_RST_DIR_D;
		end else if (acc_wr && (idx == `PSP_IDX_PORT_D_DIR)) begin
			dir_d_q <= pwdata[7:0];
		end
	end

	// Analog pin configuration
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			cfg_q <= `PSP_RST_CFG;
		end else if (acc_wr && (idx == `PSP_IDX_PIN_CFG)) begin
			cfg_q <= pwdata[2:0];
		end
	end

	// Port E data latch
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			port_e_q <= `PSP_RST_BYTE;
		end else if (acc_wr && (idx == `PSP_IDX_PORT_E)) begin
			port_e_q <= pwdata[7:0];
		end
	end

	// Interrupt control storage
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			int_ctrl_q <= `PSP_RST_BYTE;
		end else if (acc_wr && (idx == `PSP_IDX_INT_CTRL)) begin
			int_ctrl_q <= pwdata[7:0];
		end
	end

	// Interrupt enables
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			int_en_q <= `PSP_RST_BYTE;
		end else if (acc_wr && (idx == `PSP_IDX_INT_EN)) begin
			int_en_q <= pwdata[7:0];
		end
	end

	// Other interrupt flags, plain storage
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			int_flags_low_q <= `PSP_RST_BYTE;
		end else if (acc_wr && (idx == `PSP_IDX_INT_FLAGS)) begin
			int_flags_low_q <= {1'b0, pwdata[6:0]};
		end
	end

	// Output latch
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			out_latch_q <= `PSP_RST_BYTE;
		end else if (acc_wr && (idx == `PSP_IDX_PORT_D)) begin
			out_latch_q <= pwdata[7:0];
		end
	end

	// Input latch follows the pins while a selected write is active
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			in_latch_q <= 8'h00;
		end else if (wr_act) begin
			in_latch_q <= pd_s2_q;
		end
	end

	// Input buffer full
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			in_full_q <= 1'b0;
		end else if (!slave_en) begin
			in_full_q <= 1'b0;
		end else if (wr_q4) begin
			in_full_q <= 1'b1;
		end else if (acc_rd && (idx == `PSP_IDX_PORT_D)) begin
			in_full_q <= 1'b0;
		end
	end

	// Output buffer full
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			out_full_q <= 1'b0;
		end else if (!slave_en) begin
			out_full_q <= 1'b0;
		end else if (acc_wr && (idx == `PSP_IDX_PORT_D)) begin
			out_full_q <= 1'b1;
		end else if (rd_start) begin
			out_full_q <= 1'b0;
		end
	end

	// Overflow, cleared only by firmware
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			in_ovf_q <= 1'b0;
		end else if (wr_start && in_full_q) begin
			in_ovf_q <= 1'b1;
		end else if (acc_wr && (idx == `PSP_IDX_DIR_STAT)) begin
			in_ovf_q <= pwdata[`PSP_BIT_IN_OVF];
		end
	end

	// Port interrupt flag
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pif_q <= 1'b0;
		end else if (wr_q4 || rd_q4) begin
			pif_q <= 1'b1;
		end else if (acc_wr && (idx == `PSP_IDX_INT_FLAGS)) begin
			pif_q <= pwdata[`PSP_BIT_PIF];
		end
	end

	assign port_int_req = pif_q && int_en_q[`PSP_BIT_PIE];

	// Pin drivers
	assign port_d_out = out_latch_q;
	assign port_d_oe  = mode_q ? {8{rd_act}} : ~dir_d_q;
	assign port_e_out = port_e_q[2:0];
	assign port_e_oe  = mode_q ? 3'h0 : ~dir_e_q;
endmodule

/* src/psp_map.svh */
`ifndef PSP_MAP_SVH
`define PSP_MAP_SVH
// Functional notes
// - Mode bit turns port D into slave port
// - Port E pins become read, write, select
// - Slave port needs inputs and digital pins
// - Separate in/out latches share one address
// - Port D direction ignored in slave mode
// - Write spans select and write both low
// - Write end sets input full at Q4
// - Same Q4 also sets port interrupt flag
// - Firmware data read or leaving slave mode clears input full
// - Write while input unread sets overflow
// - Read start clears output full at once
// - Read end sets interrupt at Q4
// - Output full stays clear until firmware write
// - Outside mode both full flags held clear
// - Interrupt flag latched; enable masks request
// - Reset clears flags, direction bits set
// - Device drives port D during selected read
// - Selected write captures port D pins
`define PSP_IDX_PORT_D       10'h008
`define PSP_IDX_PORT_E       10'h009
`define PSP_IDX_INT_CTRL     10'h00B
`define PSP_IDX_INT_FLAGS    10'h00C
`define PSP_IDX_PORT_D_DIR   10'h088
`define PSP_IDX_DIR_STAT     10'h089
`define PSP_IDX_INT_EN       10'h08C
`define PSP_IDX_PIN_CFG      10'h09F
`define PSP_BIT_IN_FULL      7
`define PSP_BIT_OUT_FULL     6
`define PSP_BIT_IN_OVF       5
`define PSP_BIT_MODE         4
`define PSP_BIT_PIF          7
`define PSP_BIT_PIE          7
`define PSP_RST_DIR_E        3'h7
`define PSP_RST_DIR_D        8'hFF
`define PSP_RST_BYTE         8'h00
`define PSP_CFG_DIGITAL      3'h7
`define PSP_RST_CFG          3'h0
`define PSP_DIR_ALL_IN       3'h7
`endif

/* src/psp_pkg.sv */
package psp_pkg;
	typedef enum logic [1:0] {PSP_Q1, PSP_Q2, PSP_Q3, PSP_Q4} psp_phase_t;
	typedef enum logic [1:0] {PSP_EV_IDLE, PSP_EV_WAIT_Q2, PSP_EV_WAIT_Q4} psp_evt_t;
endpackage

/* testbench/psp_monitor.sv */
`timescale 1ns/1ps
module psp_monitor (
	input wire logic        clock,
	input wire logic        rst_b,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [7:0]  port_d_oe,
	input wire logic [2:0]  port_e_in,
	input wire logic [2:0]  port_e_oe,
	input wire logic        port_int_req
);
	logic [5:0] idle_q;
	logic       wr_acc;
	logic       rd_act;
	assign wr_acc = psel & penable & pwrite;
	assign rd_act = ~port_e_in[2] & ~port_e_in[0];
	// Cycles since a strobe pair was last seen low
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) idle_q <= 6'h3F;
		else if (~port_e_in[2] & ~&port_e_in[1:0]) idle_q <= 6'h00;
		else if (idle_q != 6'h3F) idle_q <= idle_q + 6'h01;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	a_ready_high: assert property (pready) else $error("pready low");
	a_err_addr: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
		else $error("no error on misaligned access");
	a_err_idle: assert property (!penable |-> !pslverr) else $error("error outside access");
	a_err_zero: assert property (penable && pslverr |-> prdata == 32'h0)
		else $error("data on refused access");
	a_rd_hold: assert property (psel && penable |=> prdata == $past(prdata))
		else $error("read data moved");
	a_rst_quiet: assert property ($rose(rst_b) |-> !port_int_req && port_d_oe == 8'h00)
		else $error("outputs active after reset");
	a_req_cause: assert property ($rose(port_int_req) && !$past(wr_acc) |->
		idle_q inside {[2:15]}) else $error("request without strobe end");
	a_req_drop: assert property ($fell(port_int_req) |-> $past(wr_acc))
		else $error("request dropped by itself");
	a_oe_lag: assert property ($rose(&port_d_oe) && !$past(wr_acc) |->
		$past(rd_act, 2) || $past(rd_act, 3)) else $error("drive without read");
endmodule
bind psp_top psp_monitor psp_monitor_i (.clock(clock), .rst_b(rst_b), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .port_d_oe(port_d_oe), .port_e_in(port_e_in),
	.port_e_oe(port_e_oe), .port_int_req(port_int_req));

/* testbench/psp_host_model.sv */
`timescale 1ns/1ps
module psp_host_model (
	input  wire logic       clock,
	input  wire logic [7:0] port_d_out,
	input  wire logic [7:0] port_d_oe,
	output logic      [2:0] port_e_in,
	output logic      [7:0] port_d_in
);
	initial begin
		port_e_in = 3'h7;
		port_d_in = 8'h00;
	end
	// Released bus shows the inverse of the last byte
	task automatic host_write(input logic [7:0] d);
		@(posedge clock);
		port_d_in <= d;
		port_e_in <= 3'h1;
		repeat (5) @(posedge clock);
		port_e_in <= 3'h7;
		@(posedge clock);
		port_d_in <= ~d;
	endtask
	task automatic host_read(output logic [7:0] d, output logic [7:0] oe);
		@(posedge clock);
		port_e_in <= 3'h2;
		repeat (5) @(posedge clock);
		d = port_d_out;
		oe = port_d_oe;
		port_e_in <= 3'h7;
	endtask
endmodule

/* testbench/parallel_slave_port_bench.sv */
`timescale 1ns/1ps
module parallel_slave_port_bench;
	typedef struct packed {
		logic [11:0] addr;
		logic [7:0]  wdat;
		logic [7:0]  exp;
	} psp_row_t;
	logic        clock, rst_b, psel, penable, pwrite, pready, pslverr, port_int_req, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [7:0]  port_d_in, port_d_out, port_d_oe, hd, hoe;
	logic [2:0]  port_e_in, port_e_oe, port_e_out;
	int          n_mismatch, n_checks;
	psp_row_t    rows [10];
	psp_top psp_top_i (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .port_d_in(port_d_in), .port_d_out(port_d_out),
		.port_d_oe(port_d_oe), .port_e_in(port_e_in), .port_e_out(port_e_out),
		.port_e_oe(port_e_oe),
		.port_int_req(port_int_req));
	psp_host_model psp_host_model_i (.clock(clock), .port_d_out(port_d_out),
		.port_d_oe(port_d_oe), .port_e_in(port_e_in), .port_d_in(port_d_in));
	initial clock = 1'h0;
	always #12.5 clock = ~clock;
	task automatic summarize;
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		int n;
		@(posedge clock);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clock);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'h1 && n < 20);
		rdat = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (pready !== 1'h1) begin
			n_mismatch++;
			summarize();
		end
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		apb(1'h0, a, 8'h00);
		chk("prdata", {24'h0, e}, rdat);
	endtask
	task automatic wait_req;
		int n;
		n = 0;
		while (port_int_req !== 1'h1 && n < 40) begin
			@(negedge clock);
			n++;
		end
		chk("port_int_req", 32'h1, {31'h0, port_int_req});
		if (port_int_req !== 1'h1) summarize();
	endtask
	initial begin
		{rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
		rows = '{'{12'h27C, 8'hFF, 8'h07}, '{12'h224, 8'h2F, 8'h27}, '{12'h224, 8'h07, 8'h07},
			'{12'h030, 8'h7F, 8'h7F}, '{12'h030, 8'h00, 8'h00}, '{12'h02C, 8'hA5, 8'hA5},
			'{12'h220, 8'h00, 8'h00}, '{12'h220, 8'hFF, 8'hFF}, '{12'h230, 8'h80, 8'h80},
			'{12'h024, 8'h05, 8'h07}};
		repeat (20) @(posedge clock);
		rst_b <= 1'h1;
		rd(12'h224, 8'h07);
		rd(12'h220, 8'hFF);
		foreach (rows[i]) begin
			apb(1'h1, rows[i].addr, rows[i].wdat);
			rd(rows[i].addr, rows[i].exp);
		end
		chk("port_e_out", 32'h5, {29'h0, port_e_out});
		apb(1'h0, 12'h400, 8'h00);
		chk("pslverr", 32'h1, {31'h0, err});
		apb(1'h1, 12'h225, 8'h10);
		rd(12'h224, 8'h07);
		apb(1'h1, 12'h224, 8'h17);
		apb(1'h1, 12'h020, 8'h3C);
		rd(12'h224, 8'h57);
		chk("port_e_oe", 32'h0, {29'h0, port_e_oe});
		psp_host_model_i.host_write(8'hA5);
		wait_req();
		rd(12'h224, 8'hD7);
		rd(12'h030, 8'h80);
		psp_host_model_i.host_write(8'h5A);
		repeat (16) @(posedge clock);
		rd(12'h224, 8'hF7);
		rd(12'h020, 8'h5A);
		rd(12'h224, 8'h77);
		apb(1'h1, 12'h030, 8'h00);
		apb(1'h1, 12'h230, 8'h00);
		psp_host_model_i.host_read(hd, hoe);
		chk("host_data", 32'h3C, {24'h0, hd});
		chk("port_d_oe", 32'hFF, {24'h0, hoe});
		repeat (16) @(posedge clock);
		rd(12'h224, 8'h37);
		rd(12'h030, 8'h80);
		chk("port_int_req", 32'h0, {31'h0, port_int_req});
		apb(1'h1, 12'h020, 8'h11);
		rd(12'h224, 8'h77);
		apb(1'h1, 12'h224, 8'h27);
		rd(12'h224, 8'h27);
		rst_b <= 1'h0;
		repeat (2) @(posedge clock);
		rst_b <= 1'h1;
		rd(12'h224, 8'h07);
		summarize();
	end
endmodule
